/* gtb_timer_bank.v */
// Purpose: Standalone 16-bit timer plus four 16/32-bit timer pairs behind an APB slave.
// Assumes: One clock pclk at 50 MHz; idle_mode and sleep_mode come from logic on pclk.
// Notes: Each external clock pin doubles as the gate input when the internal clock is used.
`include "gtb_map.vh"
`default_nettype none

module gtb_timer_bank (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [8:0] ext_clock_pin,
	input wire idle_mode,
	input wire sleep_mode,
	output reg [8:0] timer_irq_flag,
	output reg [1:0] converter_trigger,
	output reg [1:0] dma_trigger,
	output wire [15:0] time_base_even,
	output wire [15:0] time_base_odd
);

	reg [8:0] pin_s1_q;
	reg [8:0] pin_s2_q;
	reg [8:0] pin_s3_q;
	wire [8:0] pin_rise;
	wire [8:0] pin_fall;
	wire [16*9-1:0] ctl_flat;
	wire [16*9-1:0] cnt_flat;
	wire [16*9-1:0] per_flat;
	wire [8:0] tick_flat;
	wire [8:0] gfall_flat;
	wire [8:0] ev_flat;
	wire wr_en;
	wire [15:0] tdec;
	wire [3:0] rdec;
	wire addr_ok;
	reg [31:0] rd_d;
	integer k;

	// Two flops before any logic looks at the pins; the third only feeds edge detection.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 9'h000;
			pin_s2_q <= 9'h000;
			pin_s3_q <= 9'h000;
		end else begin
			pin_s1_q <= ext_clock_pin;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end
	assign pin_rise = pin_s2_q & ~pin_s3_q;
	assign pin_fall = ~pin_s2_q & pin_s3_q;

	// Writes land only at the access edge that samples pready high.
	assign wr_en = psel & penable & pwrite & pready & ~pslverr;
	assign tdec = 16'h0001 << paddr[7:4];
	assign rdec = 4'h1 << paddr[3:2];
	assign addr_ok = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
		(((paddr[7:4] < `GTB_FLAGS_TIMER) && (paddr[3:2] != 2'h3)) ||
		(paddr[7:0] == `GTB_ADDR_FLAGS));

	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1) begin : g_tmr
			localparam integer LO = (gi == 0) ? 0 : ((gi % 2 == 1) ? gi : gi - 1);
			localparam integer HI = (gi == 0) ? 0 : LO + 1;
			localparam ODD = (gi != 0) && (gi % 2 == 0);
			localparam [15:0] WMASK = (gi == 0) ? `GTB_MASK_STANDALONE :
				(ODD ? `GTB_MASK_ODD : `GTB_MASK_EVEN);
			reg [15:0] ctl_q;
			reg [15:0] cnt_q;
			reg [15:0] per_q;
			reg [7:0] pre_q;
			wire wr_ctl;
			wire wr_cnt;
			wire wr_per;
			wire cs;
			wire gated;
			wire src;
			wire unsync;
			wire run;
			wire [7:0] last;
			wire adv;
			wire tick;
			wire wide;
			wire [31:0] cnt32;
			wire [31:0] per32;
			wire m32;
			wire own_ev;

			assign wr_ctl = wr_en & tdec[gi] & rdec[`GTB_OFF_CTRL];
			assign wr_cnt = wr_en & tdec[gi] & rdec[`GTB_OFF_COUNT];
			assign wr_per = wr_en & tdec[gi] & rdec[`GTB_OFF_PERIOD];
			assign cs = ctl_q[`GTB_BIT_CLK_SRC];
			assign gated = ctl_q[`GTB_BIT_GATED] & ~cs;
			// Internal clock counts every cycle, or every cycle the gate stands high.
			assign src = cs ? pin_rise[gi] : (gated ? pin_s2_q[gi] : 1'b1);
			// With one clock the unsynchronized mode still samples the pin; it differs
			// only in that it keeps counting while the core sleeps.
			assign unsync = (gi == 0) & cs & ~ctl_q[`GTB_BIT_EXT_SYNC];
			assign run = ctl_q[`GTB_BIT_RUN] & ~(ctl_q[`GTB_BIT_IDLE_HALT] & idle_mode) &
				~(sleep_mode & ~unsync);
			assign last = (ctl_q[5:4] == 2'b11) ? `GTB_PS_LAST_256 :
				(ctl_q[5:4] == 2'b10) ? `GTB_PS_LAST_64 :
				(ctl_q[5:4] == 2'b01) ? `GTB_PS_LAST_8 : `GTB_PS_LAST_1;
			assign adv = run & src;
			assign tick = adv & (pre_q == last);
			assign wide = (gi != 0) & ctl_flat[LO*16+`GTB_BIT_PAIR_WIDE];
			assign cnt32 = {cnt_flat[HI*16 +: 16], cnt_flat[LO*16 +: 16]};
			assign per32 = {per_flat[HI*16 +: 16], per_flat[LO*16 +: 16]};
			assign m32 = (cnt32 == per32);
			assign own_ev = (tick & (cnt_q == per_q)) | gfall_flat[gi];
			assign ev_flat[gi] = wide ? (ODD ? ((tick_flat[LO] & m32) | gfall_flat[LO]) : 1'b0)
				: own_ev;
			assign tick_flat[gi] = tick;
			assign gfall_flat[gi] = run & gated & pin_fall[gi];
			assign ctl_flat[gi*16 +: 16] = ctl_q;
			assign cnt_flat[gi*16 +: 16] = cnt_q;
			assign per_flat[gi*16 +: 16] = per_q;

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctl_q <= `GTB_RESET_CTRL;
					per_q <= `GTB_RESET_PERIOD;
					pre_q <= 8'h00;
				end else begin
					if (wr_ctl) begin
						ctl_q <= pwdata[15:0] & WMASK;
					end
					if (wr_per) begin
						per_q <= pwdata[15:0];
					end
					// A control write restarts the divider so a new ratio starts clean.
					if (wr_ctl) begin
						pre_q <= 8'h00;
					end else if (adv) begin
						pre_q <= tick ? 8'h00 : pre_q + 8'h01;
					end
				end
			end

			// A software write to the count wins over a count edge in the same cycle.
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_q <= `GTB_RESET_COUNT;
				end else if (wr_cnt) begin
					cnt_q <= pwdata[15:0];
				end else if (wide) begin
					if (tick_flat[LO]) begin
						if (m32) begin
							cnt_q <= 16'h0000;
						end else if (!ODD || cnt_flat[LO*16 +: 16] == 16'hFFFF) begin
							cnt_q <= cnt_q + 16'h0001;
						end
					end
				end else if (tick) begin
					cnt_q <= (cnt_q == per_q) ? 16'h0000 : cnt_q + 16'h0001;
				end
			end
		end
	endgenerate

	// Sticky flags: software clears by writing one; a new event in that cycle wins.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_irq_flag <= 9'h000;
			converter_trigger <= 2'b00;
			dma_trigger <= 2'b00;
		end else begin
			if (wr_en && paddr[7:0] == `GTB_ADDR_FLAGS) begin
				timer_irq_flag <= (timer_irq_flag & ~pwdata[8:0]) | ev_flat;
			end else begin
				timer_irq_flag <= timer_irq_flag | ev_flat;
			end
			converter_trigger <= {ev_flat[4], ev_flat[2]};
			dma_trigger <= {ev_flat[2], ev_flat[1]};
		end
	end

	assign time_base_even = cnt_flat[1*16 +: 16];
	assign time_base_odd = cnt_flat[2*16 +: 16];

	always @* begin
		rd_d = 32'h00000000;
		for (k = 0; k < 9; k = k + 1) begin
			if (tdec[k]) begin
				if (rdec[`GTB_OFF_CTRL]) begin
					rd_d = {16'h0000, ctl_flat[k*16 +: 16]};
				end else if (rdec[`GTB_OFF_COUNT]) begin
					rd_d = {16'h0000, cnt_flat[k*16 +: 16]};
				end else if (rdec[`GTB_OFF_PERIOD]) begin
					rd_d = {16'h0000, per_flat[k*16 +: 16]};
				end
			end
		end
		if (paddr[7:0] == `GTB_ADDR_FLAGS) begin
			rd_d = {23'h000000, timer_irq_flag};
		end
		if (!addr_ok) begin
			rd_d = 32'h00000000;
		end
	end

	// No wait state: read data and error are settled in the setup cycle, so the access
	// phase completes at its first edge; the two count words of a pair are read in separate accesses.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h00000000 : rd_d;
			end
		end
	end

endmodule

`default_nettype wire

/* gtb_map.vh */
// Purpose: Register offsets, field positions, masks and reset values of the timer bank.
// Assumes: APB byte addresses, one 32-bit word per register, 16-bit data in the low bits.
// Notes: Timer 0 is the standalone timer; timers 1..8 form four pairs (even=1,3,5,7).
`ifndef GTB_MAP_VH
`define GTB_MAP_VH

`define GTB_NUM_TIMERS 9
`define GTB_TIMER_STRIDE 12'h010
`define GTB_OFF_CTRL 2'h0
`define GTB_OFF_COUNT 2'h1
`define GTB_OFF_PERIOD 2'h2
`define GTB_FLAGS_TIMER 4'h9
`define GTB_ADDR_FLAGS 12'h090

`define GTB_BIT_RUN 15
`define GTB_BIT_IDLE_HALT 13
`define GTB_BIT_GATED 6
`define GTB_BIT_PRESCALE_HI 5
`define GTB_BIT_PRESCALE_LO 4
`define GTB_BIT_PAIR_WIDE 3
`define GTB_BIT_EXT_SYNC 2
`define GTB_BIT_CLK_SRC 1

`define GTB_MASK_STANDALONE 16'hA076
`define GTB_MASK_EVEN 16'hA07A
`define GTB_MASK_ODD 16'hA072

`define GTB_RESET_CTRL 16'h0000
`define GTB_RESET_COUNT 16'h0000
`define GTB_RESET_PERIOD 16'hFFFF

`define GTB_PS_LAST_1 8'h00
`define GTB_PS_LAST_8 8'h07
`define GTB_PS_LAST_64 8'h3F
`define GTB_PS_LAST_256 8'hFF

`endif

/* gtb_props.sv */
// Purpose: Port-level checks of the timer bank.
// Assumes: Single pclk domain, presetn active low.
// Notes: Bound to the top module at the foot of this file.
`default_nettype none
module gtb_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [8:0] timer_irq_flag,
	input wire logic [1:0] converter_trigger,
	input wire logic [1:0] dma_trigger,
	input wire logic [15:0] time_base_even
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic wr = psel & penable & pready & pwrite;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	AST_READY: assert property (s_setup |=> s_access)
		else $error("no ready after setup");
	AST_RESET: assert property ($rose(presetn) |-> !timer_irq_flag && !time_base_even)
		else $error("state not clear after reset");
	AST_STEP: assert property ($changed(time_base_even) && !$past(wr) |->
		time_base_even == 16'h0 || time_base_even - $past(time_base_even) == 16'h1)
		else $error("count jumped");
	AST_WRAP: assert property (time_base_even == 16'h0 && $changed(time_base_even) &&
		$past(time_base_even) != 16'hFFFF && !$past(wr) |-> timer_irq_flag[2:1] != 2'h0)
		else $error("wrap without flag");
	AST_CLEAR: assert property ($fell(timer_irq_flag[1]) |->
		$past(wr && paddr == 12'h090 && pwdata[1])) else $error("flag lost");
	AST_CONV0: assert property (converter_trigger[0] |-> timer_irq_flag[2])
		else $error("trigger without event");
	AST_CONV1: assert property (converter_trigger[1] |-> timer_irq_flag[4])
		else $error("trigger without event");
	AST_DMA: assert property (dma_trigger[1] |-> timer_irq_flag[2])
		else $error("dma trigger without event");
endmodule
bind gtb_timer_bank gtb_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.timer_irq_flag(timer_irq_flag), .converter_trigger(converter_trigger),
	.dma_trigger(dma_trigger), .time_base_even(time_base_even));
`default_nettype wire

/* gtb_pin_model.sv */
// Purpose: Drives the external clock and gate pins of the timer bank.
// Assumes: Pins idle low between bursts.
// Notes: Levels last two cycles or more so the pin synchronizer never misses one.
`default_nettype none
module gtb_pin_model (
	input wire logic pclk,
	output var logic [8:0] pin
);
	initial pin = 9'h000;
	task automatic pulses(input int idx, input int n);
		repeat (n) begin
			@(posedge pclk) pin[idx] <= 1'h1;
			repeat (2) @(posedge pclk);
			pin[idx] <= 1'h0;
			repeat (2) @(posedge pclk);
		end
	endtask
	task automatic gate(input int idx, input int n);
		@(posedge pclk) pin[idx] <= 1'h1;
		repeat (n) @(posedge pclk);
		pin[idx] <= 1'h0;
	endtask
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for the timer bank.
// Assumes: pclk 50 MHz; the APB slave answers by pready.
// Notes: A start/stop pair spans k+3 counting edges, so counts are exact.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic idle_mode = 1'h0, sleep_mode = 1'h0, pready, pslverr, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [8:0] pins, flags;
	logic [15:0] even_cnt, odd_cnt;
	logic [1:0] conv_t, dma_t;
	int conv_n = 0, dma_n = 0;
	int err_count = 0, samples_checked = 0;
	int dv[4] = '{1, 8, 64, 256};
	gtb_pin_model pm (.pclk(pclk), .pin(pins));
	gtb_timer_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clock_pin(pins), .idle_mode(idle_mode),
		.sleep_mode(sleep_mode), .timer_irq_flag(flags), .converter_trigger(conv_t),
		.dma_trigger(dma_t), .time_base_even(even_cnt), .time_base_odd(odd_cnt));
	initial forever #10 pclk = ~pclk;
	// Trigger pulses last one cycle, so they are counted as they pass.
	always @(posedge pclk) begin
		if (conv_t[1] === 1'h1) conv_n <= conv_n + 1;
		if (dma_t[0] === 1'h1) dma_n <= dma_n + 1;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic run(input logic [11:0] a, input logic [15:0] c, input int k);
		apb(1'h1, a, {16'h0, c});
		repeat (k) @(posedge pclk);
		apb(1'h1, a, 32'h0);
		apb(1'h0, a + 12'h4, 32'h0);
	endtask
	task automatic t_regs;
		logic [15:0] m[3] = '{16'hA076, 16'hA07A, 16'hA072};
		apb(1'h0, 12'h008, 32'h0);
		chk(rd, 32'hFFFF);
		apb(1'h0, 12'h0A0, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		for (int i = 0; i < 3; i++) begin
			apb(1'h1, 12'(i * 16), 32'hFFFF);
			apb(1'h0, 12'(i * 16), 32'h0);
			chk(rd, {16'h0, m[i]});
			apb(1'h1, 12'(i * 16), 32'h0);
		end
	endtask
	task automatic t_pre;
		for (int c = 0; c < 4; c++) begin
			apb(1'h1, 12'h004, 32'h0);
			run(12'h000, 16'h8000 | 16'(c << 4), 4 * dv[c]);
			chk(rd, (c == 0) ? 32'h7 : 32'h4);
		end
	endtask
	task automatic t_match;
		apb(1'h1, 12'h028, 32'h1);
		apb(1'h1, 12'h020, 32'h8000);
		apb(1'h1, 12'h018, 32'h2);
		apb(1'h1, 12'h014, 32'h0);
		run(12'h010, 16'h8000, 4);
		chk(rd, 32'h1);
		chk({16'h0, even_cnt}, 32'h1);
		chk({31'h0, flags[1]}, 32'h1);
		chk(dma_n, 32'h2);
		apb(1'h1, 12'h020, 32'h0);
		apb(1'h1, 12'h024, 32'h5);
		chk({16'h0, odd_cnt}, 32'h5);
		apb(1'h1, 12'h090, 32'h1FF);
		chk({23'h0, flags}, 32'h0);
	endtask
	task automatic t_idle;
		idle_mode <= 1'h1;
		apb(1'h1, 12'h004, 32'h0);
		run(12'h000, 16'hA000, 4);
		chk(rd, 32'h0);
		run(12'h000, 16'h8000, 4);
		chk(rd, 32'h7);
		idle_mode <= 1'h0;
	endtask
	task automatic t_wide;
		logic [11:0] a[6] = '{12'h030, 12'h048, 12'h038, 12'h034, 12'h044, 12'h040};
		logic [15:0] d[6] = '{16'h8, 16'h1, 16'h2, 16'hFFFE, 16'h0, 16'h30};
		foreach (a[i]) apb(1'h1, a[i], {16'h0, d[i]});
		run(12'h030, 16'h8008, 1);
		chk(rd, 32'h2);
		apb(1'h0, 12'h044, 32'h0);
		chk(rd, 32'h1);
		chk({31'h0, flags[4]}, 32'h0);
		run(12'h030, 16'h8008, 0);
		apb(1'h0, 12'h044, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, flags[4:3]}, 32'h2);
		chk(conv_n, 32'h1);
	endtask
	task automatic t_ext;
		logic [15:0] c[3] = '{16'h8002, 16'h8006, 16'h8006};
		for (int i = 0; i < 3; i++) begin
			sleep_mode <= (i < 2);
			apb(1'h1, 12'h004, 32'h0);
			apb(1'h1, 12'h000, {16'h0, c[i]});
			pm.pulses(0, 5);
			repeat (4) @(posedge pclk);
			run(12'h000, 16'h0, 0);
			chk(rd, (i == 1) ? 32'h0 : 32'h5);
		end
		sleep_mode <= 1'h0;
	endtask
	task automatic t_gate;
		apb(1'h1, 12'h018, 32'hFFFF);
		apb(1'h1, 12'h014, 32'h0);
		apb(1'h1, 12'h010, 32'h8040);
		pm.gate(1, 20);
		repeat (4) @(posedge pclk);
		run(12'h010, 16'h0, 0);
		chk(rd, 32'h14);
		chk({31'h0, flags[1]}, 32'h1);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_regs();
		t_pre();
		t_match();
		t_idle();
		t_wide();
		t_ext();
		t_gate();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		report_and_stop();
	end
endmodule
`default_nettype wire
